/* File: ldpbc_pkg.sv */
// package for the led driver power and brightness control block
// assumes a 50 MHz core clock; every cycle count below is derived from it
package ldpbc_pkg;
  // clock
  localparam int CLK_PERIOD_NS   = 20;            // core clock period
  // single-wire receiver timing
  localparam int WIRE_RESET_NS   = 100000;        // line held high this long clears bit counters
  localparam int WIRE_RESET_CYC  = (WIRE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // least time, rounded up
  localparam int WIRE_CNT_W      = 16;            // phase counter width, saturates
  // brightness word
  localparam int CODE_W          = 5;             // code width, bits 4..0
  localparam int CODE_BITS       = 5;             // bits in one word
  localparam logic [4:0] BRIGHT_RESET = 5'h1f;    // full brightness after power-on
  localparam logic [4:0] BRIGHT_OFF   = 5'h00;    // code that turns the leds off
  // soft-start ramp
  localparam int RAMP_W          = 8;             // ramp level width
  localparam logic [7:0] RAMP_TOP = 8'hff;        // ramp end level
  localparam int SS_STEP_NS      = 1000;          // time per ramp step
  localparam int SS_STEP_CYC     = SS_STEP_NS / CLK_PERIOD_NS;  // longest time, rounded down
  // channel headroom detector and mode selector
  localparam int NUM_CHAN        = 3;             // led channels
  localparam int CATH_W          = 8;             // digitised cathode headroom width
  localparam logic [7:0] CATH_LOW_TH  = 8'h20;    // below this the worst channel starves
  localparam logic [7:0] CATH_HIGH_TH = 8'h60;    // above this a lower mode would do
  localparam int MODE_DWELL_NS   = 10000;         // condition must persist this long to switch
  localparam int MODE_DWELL_CYC  = MODE_DWELL_NS / CLK_PERIOD_NS;
  localparam int DWELL_W         = 12;            // dwell counter width

  typedef enum logic [1:0] {MODE_LINEAR, MODE_PUMP_3_2, MODE_PUMP_2_1} ldpbc_mode_t;
  typedef enum logic [1:0] {SS_OFF, SS_RAMP, SS_RUN} ldpbc_ss_t;
endpackage : ldpbc_pkg

/* File: ldpbc_wire_rx.sv */
// single-wire brightness word receiver
// assumes lineSync is already synchronised to clk; idle line is high
`timescale 1ns/100ps
module ldpbc_wire_rx
  import ldpbc_pkg::*;
#(
  parameter int RESET_CYC = ldpbc_pkg::WIRE_RESET_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          lineSync,
  output logic                               wordValid,
  output logic [ldpbc_pkg::CODE_W-1:0]       wordCode
);
  logic                  linePrev_reg;     // line one cycle ago
  logic                  lineFall;         // falling edge seen
  logic                  lineRise;         // rising edge seen
  logic [WIRE_CNT_W-1:0] lowCnt_reg;       // cycles low in current bit
  logic [WIRE_CNT_W-1:0] highCnt_reg;      // cycles high since last fall
  logic                  wireReset;        // long high: clear counters
  logic                  inBit_reg;        // a bit period is open
  logic [2:0]            bitCnt_reg;       // bits decided so far
  logic [CODE_W-1:0]     shift_reg;        // collected bits
  logic                  latched_reg;      // word already handed on
  logic                  bitVal;           // decided bit value

  assign lineFall  = linePrev_reg & ~lineSync;
  assign lineRise  = ~linePrev_reg & lineSync;
  assign wireReset = (highCnt_reg >= WIRE_CNT_W'(RESET_CYC));
  assign bitVal    = (highCnt_reg > lowCnt_reg);

  // edge history; reset high so an idle line shows no edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) linePrev_reg <= 1'b1;
    else         linePrev_reg <= lineSync;
  end

  // phase timers on the core clock, saturating so long phases stay safe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowCnt_reg  <= '0;
      highCnt_reg <= '0;
    end else if (lineFall) begin
      lowCnt_reg  <= WIRE_CNT_W'(1);
      highCnt_reg <= '0;
    end else if (lineSync) begin
      if (~&highCnt_reg) highCnt_reg <= highCnt_reg + 1'b1;
    end else begin
      if (~&lowCnt_reg) lowCnt_reg <= lowCnt_reg + 1'b1;
    end
  end

  // each fall closes the previous bit; lsb arrives first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      inBit_reg  <= 1'b0;
      bitCnt_reg <= '0;
      shift_reg  <= '0;
    end else if (lineFall) begin
      // the high timer still holds the idle count on the first fall of a word,
      // so a pending line reset clears the counters here instead of eating the fall
      inBit_reg <= 1'b1;
      if (wireReset) begin
        bitCnt_reg <= '0;
      end else if (inBit_reg && bitCnt_reg < 3'(CODE_BITS)) begin
        shift_reg[bitCnt_reg] <= bitVal;
        bitCnt_reg            <= bitCnt_reg + 1'b1;
      end
    end else if (wireReset) begin
      inBit_reg  <= 1'b0;
      bitCnt_reg <= '0;
    end
  end

  // hand over once at the rise after the fifth bit; extra bits ignored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wordValid   <= 1'b0;
      wordCode    <= '0;
      latched_reg <= 1'b0;
    end else begin
      wordValid <= 1'b0;
      if (wireReset) begin
        latched_reg <= 1'b0;
      end else if (lineRise && bitCnt_reg == 3'(CODE_BITS) && !latched_reg) begin
        wordValid   <= 1'b1;
        wordCode    <= shift_reg;
        latched_reg <= 1'b1;
      end
    end
  end

  property p_wire_reset;
    @(posedge clk) disable iff (sys_rst) wireReset |=> (bitCnt_reg == 3'd0) && (inBit_reg == $past(lineFall));
  endproperty
  a_wire_reset: assert property (p_wire_reset) else $error("bit counters not cleared");

  property p_latch_five;
    @(posedge clk) disable iff (sys_rst)
      wordValid |-> $past(bitCnt_reg) == 3'd5 && $past(lineRise) && wordCode == $past(shift_reg);
  endproperty
  a_latch_five: assert property (p_latch_five) else $error("word latched without five bits");
endmodule : ldpbc_wire_rx

/* File: ldpbc_ctrl.sv */
// power-up, soft-start, brightness and pump-mode control of the led driver
// assumes enable and data pins are asynchronous; cathode headroom codes come
// from an on-clock converter, one code per channel
`timescale 1ns/100ps
module ldpbc_ctrl
  import ldpbc_pkg::*;
#(
  parameter int RESET_CYC = ldpbc_pkg::WIRE_RESET_CYC,
  parameter int NCH       = ldpbc_pkg::NUM_CHAN
) (
  input  wire logic                                clk,
  input  wire logic                                sys_rst,
  input  wire logic                                enablePin,
  input  wire logic                                dataPin,
  input  wire logic [NCH-1:0][ldpbc_pkg::CATH_W-1:0] chanHeadroom,
  output logic [ldpbc_pkg::CODE_W-1:0]             brightnessCode,
  output logic                                     ledCurrentOn,
  output logic                                     powerUpRequest,
  output logic                                     lowPower,
  output logic                                     softStartActive,
  output logic [ldpbc_pkg::RAMP_W-1:0]             rampLevel,
  output ldpbc_pkg::ldpbc_mode_t                   pumpMode,
  output logic [1:0]                               worstChannel,
  output logic [ldpbc_pkg::CATH_W-1:0]             worstHeadroom
);
  import ldpbc_pkg::*;

  logic                  enMeta_reg;        // enable synchroniser, first stage
  logic                  enSync_reg;        // enable synchroniser, second stage
  logic                  enPrev_reg;        // enable one cycle ago
  logic                  dataMeta_reg;      // data synchroniser, first stage
  logic                  dataSync_reg;      // data synchroniser, second stage
  logic                  enRise;            // enable went high
  logic                  enFall;            // enable went low
  logic                  wordValid;         // new command word
  logic [CODE_W-1:0]     wordCode;          // its code
  logic                  powerUp_reg;       // internal power-up request
  logic                  powerPrev_reg;     // request one cycle ago
  ldpbc_ss_t             ssState_reg;       // soft-start state
  logic [15:0]           ssTick_reg;        // cycles within one ramp step
  logic [DWELL_W-1:0]    upCnt_reg;         // cycles headroom has been short
  logic [DWELL_W-1:0]    downCnt_reg;       // cycles headroom has been ample
  logic [CATH_W-1:0]     minHead;           // smallest headroom this cycle
  logic [1:0]            minIdx;            // channel that owns it

  assign enRise         = enSync_reg & ~enPrev_reg;
  assign enFall         = ~enSync_reg & enPrev_reg;
  assign powerUpRequest = powerUp_reg;

  // two-flop synchronisers; nothing reads the first stage but the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enMeta_reg   <= 1'b0;
      enSync_reg   <= 1'b0;
      enPrev_reg   <= 1'b0;
      dataMeta_reg <= 1'b1;
      dataSync_reg <= 1'b1;
    end else begin
      enMeta_reg   <= enablePin;
      enSync_reg   <= enMeta_reg;
      enPrev_reg   <= enSync_reg;
      dataMeta_reg <= dataPin;
      dataSync_reg <= dataMeta_reg;
    end
  end

  // serial word receiver
  ldpbc_wire_rx #(
    .RESET_CYC (RESET_CYC)
  ) u_rx (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .lineSync  (dataSync_reg),
    .wordValid (wordValid),
    .wordCode  (wordCode)
  );

  // brightness code: full scale after power-on, then last received word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)        brightnessCode <= BRIGHT_RESET;
    else if (wordValid) brightnessCode <= wordCode;
  end

  // power-up request; starts low so enable low at power-on stays asleep.
  // an enable edge outranks a word landing in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)        powerUp_reg <= 1'b0;
    else if (enRise)    powerUp_reg <= 1'b1;
    else if (enFall)    powerUp_reg <= 1'b0;
    else if (wordValid) powerUp_reg <= (wordCode != BRIGHT_OFF);
  end

  // low-power flag follows the request; current-enable follows it only while the brightness code is non-zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowPower      <= 1'b1;
      ledCurrentOn  <= 1'b0;
      powerPrev_reg <= 1'b0;
    end else begin
      lowPower      <= ~powerUp_reg;
      ledCurrentOn  <= powerUp_reg && (brightnessCode != BRIGHT_OFF);
      powerPrev_reg <= powerUp_reg;
    end
  end

  // soft-start: linear ramp of the pump target, restarted on each power-up
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ssState_reg     <= SS_OFF;
      ssTick_reg      <= '0;
      rampLevel       <= '0;
      softStartActive <= 1'b0;
    end else if (!powerUp_reg) begin
      ssState_reg     <= SS_OFF;
      ssTick_reg      <= '0;
      rampLevel       <= '0;
      softStartActive <= 1'b0;
    end else begin
      unique case (ssState_reg)
        SS_OFF: begin
          ssState_reg     <= SS_RAMP;
          ssTick_reg      <= '0;
          rampLevel       <= '0;
          softStartActive <= 1'b1;
        end
        SS_RAMP: begin
          if (ssTick_reg == 16'(SS_STEP_CYC - 1)) begin
            ssTick_reg <= '0;
            if (rampLevel == RAMP_TOP) begin
              ssState_reg     <= SS_RUN;
              softStartActive <= 1'b0;
            end else begin
              rampLevel <= rampLevel + 1'b1;
            end
          end else begin
            ssTick_reg <= ssTick_reg + 1'b1;
          end
        end
        SS_RUN: begin
          softStartActive <= 1'b0;
        end
      endcase
    end
  end

  // find the channel with least cathode headroom, the one needing most voltage
  always_comb begin
    minHead = chanHeadroom[0];
    minIdx  = 2'd0;
    for (int i = 1; i < NCH; i++) begin
      if (chanHeadroom[i] < minHead) begin
        minHead = chanHeadroom[i];
        minIdx  = 2'(i);
      end
    end
  end

  // register the detector result; it is the pump regulation feedback
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      worstHeadroom <= '0;
      worstChannel  <= '0;
    end else begin
      worstHeadroom <= minHead;
      worstChannel  <= minIdx;
    end
  end

  // dwell counters: two thresholds plus a persistence time give hysteresis,
  // so the selector cannot chatter at a single trip point
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      upCnt_reg   <= '0;
      downCnt_reg <= '0;
    end else if (ssState_reg != SS_RUN || upCnt_reg == DWELL_W'(MODE_DWELL_CYC - 1)
                 || downCnt_reg == DWELL_W'(MODE_DWELL_CYC - 1)) begin
      upCnt_reg   <= '0;
      downCnt_reg <= '0;
    end else begin
      upCnt_reg   <= (worstHeadroom < CATH_LOW_TH)  ? upCnt_reg + 1'b1   : '0;
      downCnt_reg <= (worstHeadroom > CATH_HIGH_TH) ? downCnt_reg + 1'b1 : '0;
    end
  end

  // pump mode selector, one step at a time, held linear until ramp done
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pumpMode <= MODE_LINEAR;
    end else if (ssState_reg != SS_RUN) begin
      pumpMode <= MODE_LINEAR;
    end else if (upCnt_reg == DWELL_W'(MODE_DWELL_CYC - 1)) begin
      unique case (pumpMode)
        MODE_LINEAR:   pumpMode <= MODE_PUMP_3_2;
        MODE_PUMP_3_2: pumpMode <= MODE_PUMP_2_1;
        MODE_PUMP_2_1: pumpMode <= MODE_PUMP_2_1;
        default:       pumpMode <= MODE_LINEAR;  // illegal code recovers
      endcase
    end else if (downCnt_reg == DWELL_W'(MODE_DWELL_CYC - 1)) begin
      unique case (pumpMode)
        MODE_PUMP_2_1: pumpMode <= MODE_PUMP_3_2;
        MODE_PUMP_3_2: pumpMode <= MODE_LINEAR;
        MODE_LINEAR:   pumpMode <= MODE_LINEAR;
        default:       pumpMode <= MODE_LINEAR;
      endcase
    end
  end

  sequence s_power_start;
    !powerPrev_reg ##1 powerUp_reg;
  endsequence
  sequence s_ramp_from_zero;
    ##1 (ssState_reg == SS_RAMP && rampLevel == 8'h00 && softStartActive);
  endsequence

  property p_en_rise;
    @(posedge clk) disable iff (sys_rst) enRise |=> powerUp_reg;
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("enable rise did not power up");

  property p_en_fall;
    @(posedge clk) disable iff (sys_rst) enFall && !enRise |=> !powerUp_reg ##1 lowPower;
  endproperty
  a_en_fall: assert property (p_en_fall) else $error("enable fall did not power down");

  property p_zero_cmd;
    @(posedge clk) disable iff (sys_rst)
      wordValid && wordCode == 5'h00 && !enRise && !enFall |=> !powerUp_reg;
  endproperty
  a_zero_cmd: assert property (p_zero_cmd) else $error("zero command kept power-up");

  property p_nonzero_cmd;
    @(posedge clk) disable iff (sys_rst)
      wordValid && wordCode != 5'h00 && !enFall |=> powerUp_reg && brightnessCode == $past(wordCode);
  endproperty
  a_nonzero_cmd: assert property (p_nonzero_cmd) else $error("nonzero command not applied");

  property p_soft_start;
    @(posedge clk) disable iff (sys_rst) s_power_start |-> s_ramp_from_zero;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("soft-start did not begin at zero");

  property p_mode_hold;
    @(posedge clk) disable iff (sys_rst) ssState_reg != SS_RUN |=> pumpMode == MODE_LINEAR;
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode left linear before ramp end");

  property p_mode_up;
    @(posedge clk) disable iff (sys_rst)
      (pumpMode == MODE_LINEAR ##1 pumpMode == MODE_PUMP_3_2) |-> $past(upCnt_reg) == DWELL_W'(MODE_DWELL_CYC - 1);
  endproperty
  a_mode_up: assert property (p_mode_up) else $error("mode stepped up without dwell");

  property p_led_off;
    @(posedge clk) disable iff (sys_rst)
      brightnessCode == 5'h00 || !powerUp_reg |=> !ledCurrentOn;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led current on with zero code or no power");

  property p_low_power;
    @(posedge clk) disable iff (sys_rst) !powerUp_reg |=> lowPower && rampLevel == 8'h00;
  endproperty
  a_low_power: assert property (p_low_power) else $error("not in low power while disabled");
endmodule : ldpbc_ctrl

/* File: ldpbc_host_model.sv */
// host model for the led driver control: drives the enable pin and the single data wire
// assumes the caller works on falling clock edges; the data wire idles high (pull-up)
`timescale 1ns/100ps
module ldpbc_host_model #(
  parameter int IDLE_CYC = 40  // high time after a word, must exceed the receiver reset time
) (
  input  wire logic clk,
  output logic      enablePin,
  output logic      dataPin
);
  // pins start idle: enable low, wire released to its pull-up level
  initial begin
    enablePin = 1'b0;
    dataPin   = 1'b1;
  end

  // drive the wire to a level for a number of cycles, changes land on falling edges
  task automatic hold(input logic lvl, input int n);
    dataPin = lvl;
    repeat (n) @(negedge clk);
  endtask : hold

  // one word, lsb first; each bit starts with a fall, dominant phase is 80 percent
  // m stretches the bit time so prompt and slow hosts are both exercised
  task automatic send_word(input logic [7:0] bits, input int nbits, input int m);
    for (int i = 0; i < nbits; i++) begin
      hold(1'b0, bits[i] ? 2 * m : 8 * m);
      hold(1'b1, bits[i] ? 8 * m : 2 * m);
    end
    hold(1'b0, 2 * m);
    hold(1'b1, IDLE_CYC);
  endtask : send_word

  // enable level change, then let one edge pass
  task automatic set_enable(input logic v);
    enablePin = v;
    @(negedge clk);
  endtask : set_enable
endmodule : ldpbc_host_model

/* File: tb_top.sv */
// self-checking bench for the led driver power and brightness control
// assumes the receiver reset time is shortened to RST_CYC cycles for run length
`timescale 1ns/100ps
module tb_top;
  import ldpbc_pkg::*;
  localparam int RST_CYC = 20;  // shortened line-high reset time
  logic                            clk, sys_rst, enablePin, dataPin;
  logic [NUM_CHAN-1:0][CATH_W-1:0] chanHeadroom;
  logic [CODE_W-1:0]               brightnessCode, prevCode;
  logic                            ledCurrentOn, powerUpRequest, lowPower, softStartActive;
  logic [RAMP_W-1:0]               rampLevel;
  ldpbc_mode_t                     pumpMode;
  logic [1:0]                      worstChannel;
  logic [CATH_W-1:0]               worstHeadroom;
  int                              failures = 0, checked = 0, cycles = 0;
  logic [31:0]                     rngState = 32'h0001_4fd4;
  logic [CODE_W-1:0]               codeNotes[$];  // expected codes, oldest first

  ldpbc_host_model #(.IDLE_CYC(2 * RST_CYC)) host (.clk(clk), .enablePin(enablePin), .dataPin(dataPin));
  ldpbc_ctrl #(.RESET_CYC(RST_CYC)) uut (
    .clk(clk), .sys_rst(sys_rst), .enablePin(enablePin), .dataPin(dataPin), .chanHeadroom(chanHeadroom),
    .brightnessCode(brightnessCode), .ledCurrentOn(ledCurrentOn), .powerUpRequest(powerUpRequest),
    .lowPower(lowPower), .softStartActive(softStartActive), .rampLevel(rampLevel), .pumpMode(pumpMode),
    .worstChannel(worstChannel), .worstHeadroom(worstHeadroom));

  // clock and timeout; the ceiling is about twice the planned run
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      failures++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xorshift();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction : xorshift

  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic chk_power(input logic pu, input logic led);
    cmp_bit(powerUpRequest, pu, "power-up request");
    cmp_bit(lowPower, !pu, "low power");
    cmp_bit(ledCurrentOn, led, "led current");
  endtask : chk_power

  // note the expected code, then let the host send it
  task automatic send(input logic [7:0] bits, input int nbits, input int m, input logic note);
    if (note) codeNotes.push_back(bits[4:0]);
    host.send_word(bits, nbits, m);
  endtask : send

  task automatic tally_and_finish();
    if (codeNotes.size() != 0) failures++;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // watcher: every change of the code takes the oldest note
  always @(negedge clk) begin
    if (sys_rst) prevCode = BRIGHT_RESET;
    else if (brightnessCode !== prevCode) begin
      if (codeNotes.size() == 0) begin
        failures++;
        $display("unexpected at %0t: code changed with nothing sent", $time);
      end
      else cmp_val(8'(brightnessCode), 8'(codeNotes.pop_front()), "code");
      prevCode = brightnessCode;
    end
  end

  // main sequence
  initial begin
    logic [CODE_W-1:0] c, last;
    logic [7:0]        mn;
    logic [1:0]        mi;
    logic              bad;
    int                n;
    sys_rst = 1'b1;
    chanHeadroom = '0;
    step(12);
    sys_rst = 1'b0;
    step(30);
    cmp_val(8'(brightnessCode), 8'h1f, "code after power-on");
    chk_power(1'b0, 1'b0);
    // worst channel detector with random headroom, ties included
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < NUM_CHAN; k++) chanHeadroom[k] = (i == 7) ? 8'h33 : 8'(xorshift());
      mn = 8'hff;
      mi = 2'd0;
      for (int k = NUM_CHAN - 1; k >= 0; k--) if (chanHeadroom[k] <= mn) begin
        mn = chanHeadroom[k];
        mi = 2'(k);
      end
      step(4);
      cmp_val(8'(worstChannel), 8'(mi), "worst channel");
      cmp_val(worstHeadroom, mn, "worst headroom");
    end
    for (int k = 0; k < NUM_CHAN; k++) chanHeadroom[k] = 8'h40;
    // non-zero command wakes the device, zero command sends it back
    send(8'h05, 5, 1, 1'b1);
    chk_power(1'b1, 1'b1);
    cmp_bit(softStartActive, 1'b1, "soft-start on word");
    send(8'h00, 5, 2, 1'b1);
    chk_power(1'b0, 1'b0);
    send(8'h07, 3, 2, 1'b0);
    chk_power(1'b0, 1'b0);
    // enable rise powers up even with code zero
    host.set_enable(1'b1);
    step(6);
    chk_power(1'b1, 1'b0);
    cmp_bit(softStartActive, 1'b1, "soft-start on enable");
    send(8'h6a, 7, 1, 1'b1);
    last = 5'h0a;
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 5'h1f : (i == 1) ? 5'h01 : 5'(xorshift());
      if (c == last) c = c ^ 5'h01;
      send({3'b000, c}, 5, 1 + i % 2, 1'b1);
      cmp_bit(ledCurrentOn, c != 5'h00, "led current");
      last = c;
    end
    // enable fall returns to low power, next rise restarts the ramp
    host.set_enable(1'b0);
    step(6);
    chk_power(1'b0, 1'b0);
    cmp_bit(softStartActive, 1'b0, "soft-start off");
    host.set_enable(1'b1);
    chanHeadroom[1] = 8'h10;
    step(6);
    cmp_bit(softStartActive, 1'b1, "ramp restart");
    cmp_bit(rampLevel < 8'h02, 1'b1, "ramp starts low");
    // low headroom during the ramp must not move the mode
    bad = 1'b0;
    n = 0;
    while (softStartActive === 1'b1 && n < 14000) begin
      if (pumpMode !== MODE_LINEAR) bad = 1'b1;
      step(1);
      n++;
    end
    cmp_bit(bad, 1'b0, "mode held during ramp");
    cmp_bit(n >= 255 * SS_STEP_CYC && n <= 257 * SS_STEP_CYC, 1'b1, "ramp length");
    step(450);
    cmp_val(8'(pumpMode), 8'(MODE_LINEAR), "mode before dwell");
    step(100);
    cmp_val(8'(pumpMode), 8'(MODE_PUMP_3_2), "mode step up");
    step(550);
    cmp_val(8'(pumpMode), 8'(MODE_PUMP_2_1), "mode second step");
    chanHeadroom[1] = 8'h40;
    step(1200);
    cmp_val(8'(pumpMode), 8'(MODE_PUMP_2_1), "mode in band");
    for (int k = 0; k < NUM_CHAN; k++) chanHeadroom[k] = 8'h80;
    step(550);
    cmp_val(8'(pumpMode), 8'(MODE_PUMP_3_2), "mode step down");
    step(550);
    cmp_val(8'(pumpMode), 8'(MODE_LINEAR), "mode back to linear");
    // second reset in mid-run with enable still high
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    step(1);
    cmp_val(8'(brightnessCode), 8'h1f, "code after reset");
    step(6);
    chk_power(1'b1, 1'b1);
    tally_and_finish();
  end
endmodule : tb_top
